// file: hdl/interrupt_enable_vectoring.v
`timescale 1ns/1ns
`include "irq_vec_map.vh"
// Notes on behaviour
// R1: Global gate bit 7 clear blocks all sources; set lets each mask decide.
// R2: Mask bit 6 gates serial peripheral interface requests.
// R3: Mask bit 5 gates both timer 2 overflow flags together.
// R4: Mask bit 4 gates the first asynchronous serial port request.
// R5: Mask bit 3 gates timer 1 overflow requests.
// R6: Mask bit 2 gates the second external pin requests.
// R7: Mask bit 1 gates timer 0 overflow requests.
// R8: Mask bit 0 gates the first external pin requests.
// R9: First external pin vectors to 0x0003, order 0, pending cleared on vectoring.
// R10: Second external pin vectors to 0x0013, order 2, pending cleared on vectoring.
// R11: Mask register sits at address 0xA8 and is bit addressable.
// R12: Equal-level simultaneous requests are served lowest tie-break order first.
// R13: High level preempts a low routine; a high routine is never preempted.
// R14: Pending flags set on their condition regardless of masking.
// R15: After the current instruction an enabled request calls the winner's vector.
// R16: Mask register resets to zero, every source masked and gate closed.
// R17: Other sources use vectors eight bytes apart from 0x000B upward.
module interrupt_enable_vectoring (
  // Clock and reset
  input wire clk_sys_i,
  input wire nrst_i,
  // Special-function register access from the core
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_bit_wr_i,
  input wire [2:0] sfr_bit_sel_i,
  input wire sfr_bit_val_i,
  output reg [7:0] sfr_rdata_o,
  // External pins, asynchronous, active high edge events
  input wire ext_pin_zero_i,
  input wire ext_pin_one_i,
  // Peripheral flags on the system clock
  input wire timer0_overflow_flag_i,
  input wire timer1_overflow_flag_i,
  input wire timer2_low_overflow_flag_i,
  input wire timer2_high_overflow_flag_i,
  input wire uart0_flag_i,
  input wire spi_flag_i,
  // Core handshake
  input wire insn_done_i,
  input wire vector_ack_i,
  input wire reti_i,
  output wire irq_req_o,
  output reg [15:0] vector_addr_o,
  output reg ext_zero_pending_o,
  output reg ext_one_pending_o
);
  localparam N = `NUM_SOURCES;
  // Two states suffice, because the core runs the call sequence itself once it is asked.
  localparam ST_IDLE = 2'h0;
  localparam ST_CALL = 2'h1;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] irq_mask_register;
  reg [6:0] prio;
  reg [2:0] ext_zero_sync;
  reg [2:0] ext_one_sync;
  reg ext_zero_level;
  reg ext_one_level;
  reg in_low;
  reg in_high;
  reg [2:0] cur_idx;
  reg cur_high;

  wire [N-1:0] flags;
  wire [N-1:0] masks;
  wire [N-1:0] gated;
  wire [N-1:0] hi_req;
  wire [N-1:0] lo_req;
  wire hi_found;
  wire lo_found;
  wire [2:0] hi_idx;
  wire [2:0] lo_idx;
  wire take_high;
  wire take_low;
  wire take;

  // Returns the register with one bit replaced, for bit-addressed writes.
  function [7:0] bit_update;
    input [7:0] old;
    input [2:0] sel;
    input val;
    begin
      bit_update = old;
      bit_update[sel] = val;
    end
  endfunction

  // Vectors sit eight bytes apart, starting at the first external pin's vector.
  function [15:0] vec_of;
    input [2:0] idx;
    begin
      vec_of = `VEC_BASE + (`VEC_STEP * {13'h0000, idx}); // R9 R10 R17
    end
  endfunction

  // True when the core accepts the call that was raised for source idx.
  function ack_for;
    input ack;
    input busy;
    input [2:0] cur;
    input [2:0] idx;
    begin
      ack_for = ack && busy && (cur == idx);
    end
  endfunction

  wire ext_zero_agree = (ext_zero_sync[2] == ext_zero_sync[1]);
  wire ext_one_agree = (ext_one_sync[2] == ext_one_sync[1]);
  wire ext_zero_rise = ext_zero_agree && ext_zero_sync[2] && !ext_zero_level;
  wire ext_one_rise = ext_one_agree && ext_one_sync[2] && !ext_one_level;
  wire in_call = (state == ST_CALL);
  wire ack_zero = ack_for(vector_ack_i, in_call, cur_idx, 3'h0);
  wire ack_one = ack_for(vector_ack_i, in_call, cur_idx, 3'h2);

  // Three-stage pin sync; only the last two stages are compared.
  // A pulse caught by a single sample never makes those two agree, so it sets nothing.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_zero_sync <= 3'h0;
      ext_one_sync <= 3'h0;
      ext_zero_level <= 1'b0;
      ext_one_level <= 1'b0;
    end else begin
      ext_zero_sync <= {ext_zero_sync[1:0], ext_pin_zero_i};
      ext_one_sync <= {ext_one_sync[1:0], ext_pin_one_i};
      if (ext_zero_agree) begin
        ext_zero_level <= ext_zero_sync[2];
      end
      if (ext_one_agree) begin
        ext_one_level <= ext_one_sync[2];
      end
    end
  end

  // Pending flags set regardless of mask; a new edge wins over the clear.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_zero_pending_o <= 1'b0;
    end else if (ext_zero_rise) begin
      ext_zero_pending_o <= 1'b1; // R14
    end else if (ack_zero) begin
      ext_zero_pending_o <= 1'b0; // R9
    end
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_one_pending_o <= 1'b0;
    end else if (ext_one_rise) begin
      ext_one_pending_o <= 1'b1; // R14
    end else if (ack_one) begin
      ext_one_pending_o <= 1'b0; // R10
    end
  end

  // A bit write wins over a byte write in the same cycle, since a bit instruction carries no byte data.
  wire hit_mask = (sfr_addr_i == `IRQ_MASK_REG_ADDR);
  wire hit_prio = (sfr_addr_i == `PRIO_REG_ADDR);
  wire [7:0] prio_bits = bit_update({1'b1, prio}, sfr_bit_sel_i, sfr_bit_val_i);

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_mask_register <= `IRQ_MASK_REG_RESET; // R16
    end else if (hit_mask) begin
      if (sfr_bit_wr_i) begin
        irq_mask_register <= bit_update(irq_mask_register, sfr_bit_sel_i, sfr_bit_val_i); // R11
      end else if (sfr_wr_i) begin
        irq_mask_register <= sfr_wdata_i; // R11
      end
    end
  end

  // Bit 7 of the priority register has no storage; writes to it are dropped and it reads one.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prio <= `PRIO_REG_RESET;
    end else if (hit_prio) begin
      if (sfr_bit_wr_i) begin
        prio <= prio_bits[6:0];
      end else if (sfr_wr_i) begin
        prio <= sfr_wdata_i[6:0];
      end
    end
  end

  // Read data is registered, so it follows the address by one clock; unmapped addresses read zero.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (hit_mask) begin
      sfr_rdata_o <= irq_mask_register;
    end else if (hit_prio) begin
      sfr_rdata_o <= {1'b1, prio};
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // Source index equals tie-break order; both timer 2 flags share one slot.
  assign flags[0] = ext_zero_pending_o;
  assign flags[1] = timer0_overflow_flag_i;
  assign flags[2] = ext_one_pending_o;
  assign flags[3] = timer1_overflow_flag_i;
  assign flags[4] = uart0_flag_i;
  assign flags[5] = timer2_low_overflow_flag_i | timer2_high_overflow_flag_i; // R3
  assign flags[6] = spi_flag_i;
  // Each mask bit sits at the same position as the order of the source it gates.
  assign masks[0] = irq_mask_register[`EXT_ZERO_MASK_BIT]; // R8
  assign masks[1] = irq_mask_register[`TIMER0_MASK_BIT]; // R7
  assign masks[2] = irq_mask_register[`EXT_ONE_MASK_BIT]; // R6
  assign masks[3] = irq_mask_register[`TIMER1_MASK_BIT]; // R5
  assign masks[4] = irq_mask_register[`UART0_MASK_BIT]; // R4
  assign masks[5] = irq_mask_register[`TIMER2_MASK_BIT]; // R3
  assign masks[6] = irq_mask_register[`SPI_MASK_BIT]; // R2
  assign gated = flags & masks & {N{irq_mask_register[`GLOBAL_GATE_BIT]}}; // R1
  assign hi_req = gated & prio;
  assign lo_req = gated & ~prio;

  // One picker per level keeps the fixed order inside each level.
  tie_break_pick #(.N(N)) u_pick_high (
    .req_i(hi_req),
    .found_o(hi_found),
    .idx_o(hi_idx)
  );

  tie_break_pick #(.N(N)) u_pick_low (
    .req_i(lo_req),
    .found_o(lo_found),
    .idx_o(lo_idx)
  );

  // High level wins over low; a running high routine blocks everything.
  assign take_high = hi_found && !in_high; // R13
  // A low request also waits behind a running low routine, as equal levels never nest.
  assign take_low = lo_found && !hi_found && !in_high && !in_low; // R12 R13
  assign take = take_high || take_low;
  assign irq_req_o = in_call;
  // The decision is taken only at an instruction boundary.
  wire launch = (state == ST_IDLE) && insn_done_i && take;
  wire [2:0] win_idx = take_high ? hi_idx : lo_idx;

  // The request stands from the clock after the decision until the core acknowledges it.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (launch) begin
          next_state = ST_CALL; // R15
        end
      end
      ST_CALL: begin
        if (vector_ack_i) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // The winner is latched with the decision, so the vector cannot move under a pending call.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_idx <= 3'h0;
      cur_high <= 1'b0;
      vector_addr_o <= 16'h0000;
    end else if (launch) begin
      cur_idx <= win_idx; // R12
      cur_high <= take_high;
      vector_addr_o <= vec_of(win_idx); // R15
    end
  end

  // Nesting is two deep at most, so two flags replace a stack.
  // A return with no routine open clears the low flag, which does no harm.
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      in_low <= 1'b0;
      in_high <= 1'b0;
    end else begin
      state <= next_state;
      if (in_call && vector_ack_i) begin
        if (cur_high) begin
          in_high <= 1'b1;
        end else begin
          in_low <= 1'b1;
        end
      end else if (reti_i) begin
        if (in_high) begin
          in_high <= 1'b0;
        end else begin
          in_low <= 1'b0;
        end
      end
    end
  end
endmodule

// file: hdl/irq_vec_map.vh
`ifndef IRQ_VEC_MAP_VH
`define IRQ_VEC_MAP_VH
`define IRQ_MASK_REG_ADDR 8'ha8
`define IRQ_MASK_REG_RESET 8'h00
`define GLOBAL_GATE_BIT 7
`define SPI_MASK_BIT 6
`define TIMER2_MASK_BIT 5
`define UART0_MASK_BIT 4
`define TIMER1_MASK_BIT 3
`define EXT_ONE_MASK_BIT 2
`define TIMER0_MASK_BIT 1
`define EXT_ZERO_MASK_BIT 0
`define PRIO_REG_ADDR 8'hb8
`define PRIO_REG_RESET 7'h00
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define NUM_SOURCES 7
`endif

// file: hdl/tie_break_pick.v
`timescale 1ns/1ns
// Picks the lowest-numbered request; index 0 is the strongest tie-break order.
module tie_break_pick #(
  parameter N = 7
) (
  // Requests
  input wire [N-1:0] req_i,
  // Result
  output reg found_o,
  output reg [2:0] idx_o
);
  integer k;
  always @* begin
    found_o = 1'b0;
    idx_o = 3'h0;
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        found_o = 1'b1;
        idx_o = k[2:0];
      end
    end
  end
endmodule

// file: verif/core_model.sv
`timescale 1ns/1ns
// An instruction ends every other cycle; a call is acked on the cycle after it is asked.
module core_model (
  // Clock and requests
  input wire clk_sys_i,
  input wire irq_i,
  input wire ret_i,
  // Core handshake
  output reg done_o = 1'b0,
  output reg ack_o = 1'b0,
  output reg reti_o = 1'b0
);
  always @(negedge clk_sys_i) begin
    done_o <= !done_o;
    ack_o <= irq_i && !ack_o;
    reti_o <= ret_i;
  end
endmodule

// file: verif/irq_checker.sv
`timescale 1ns/1ns
`include "irq_vec_map.vh"
module irq_checker (
  // Clock, reset and register port
  input wire clk_sys_i,
  input wire nrst_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_bit_wr_i,
  input wire [2:0] sfr_bit_sel_i,
  input wire sfr_bit_val_i,
  input wire [7:0] sfr_rdata_o,
  // Core handshake
  input wire insn_done_i,
  input wire vector_ack_i,
  input wire irq_req_o,
  input wire [15:0] vector_addr_o,
  input wire ext_zero_pending_o,
  input wire ext_one_pending_o
);
  // Shadow of the mask register, so requests can be judged against it.
  reg [7:0] mask;
  wire hit = sfr_addr_i == `IRQ_MASK_REG_ADDR;
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) mask <= `IRQ_MASK_REG_RESET;
    else if (sfr_bit_wr_i && hit) mask[sfr_bit_sel_i] <= sfr_bit_val_i;
    else if (sfr_wr_i && hit) mask <= sfr_wdata_i;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_served;
    irq_req_o && vector_ack_i;
  endsequence
  AST_READ: assert property ($past(hit) |-> sfr_rdata_o == $past(mask))
    else $error("mask readback");
  AST_GATE: assert property ($rose(irq_req_o) |-> $past(mask[`GLOBAL_GATE_BIT]))
    else $error("gate closed");
  AST_MASK: assert property ($rose(irq_req_o) |-> (($past(mask) >> vector_addr_o[5:3]) & 8'h01) != 8'h00)
    else $error("source masked");
  AST_VEC: assert property (irq_req_o |-> vector_addr_o[2:0] == 3'h3 && vector_addr_o < 16'h0038)
    else $error("bad vector");
  AST_TAKE: assert property ($rose(irq_req_o) |-> $past(insn_done_i))
    else $error("call mid-instruction");
  AST_HOLD: assert property (irq_req_o && !vector_ack_i |=> irq_req_o && $stable(vector_addr_o))
    else $error("request dropped");
  AST_ACK: assert property (s_served |=> !irq_req_o)
    else $error("request after ack");
  AST_EXT0: assert property (s_served ##0 vector_addr_o == 16'h0003 |=> !ext_zero_pending_o)
    else $error("pin zero pending kept");
  AST_EXT1: assert property (s_served ##0 vector_addr_o == 16'h0013 |=> !ext_one_pending_o)
    else $error("pin one pending kept");
endmodule

// file: verif/tb_interrupt_enable_vectoring.sv
`timescale 1ns/1ns
`include "irq_vec_map.vh"
module tb_interrupt_enable_vectoring;
  reg clk_sys_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [7:0] sfr_addr_i = 8'h00;
  reg sfr_wr_i = 1'b0;
  reg [7:0] sfr_wdata_i = 8'h00;
  reg sfr_bit_wr_i = 1'b0;
  reg [2:0] sfr_bit_sel_i = 3'h0;
  reg sfr_bit_val_i = 1'b0;
  reg [7:0] src = 8'h00;
  reg ret = 1'b0;
  wire [7:0] sfr_rdata_o;
  wire [15:0] vector_addr_o;
  wire irq_req_o, insn_done_i, vector_ack_i, reti_i, ext_zero_pending_o, ext_one_pending_o;
  integer error_cnt = 0;
  integer compares = 0;
  integer k;
  integer m;
  initial forever #25 clk_sys_i = !clk_sys_i;
  core_model i_core (.clk_sys_i, .irq_i(irq_req_o), .ret_i(ret), .done_o(insn_done_i), .ack_o(vector_ack_i),
    .reti_o(reti_i));
  interrupt_enable_vectoring i_dut (.clk_sys_i, .nrst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_bit_wr_i,
    .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_rdata_o, .ext_pin_zero_i(src[0]), .ext_pin_one_i(src[2]),
    .timer0_overflow_flag_i(src[1]), .timer1_overflow_flag_i(src[3]), .timer2_low_overflow_flag_i(src[5]),
    .timer2_high_overflow_flag_i(src[7]), .uart0_flag_i(src[4]), .spi_flag_i(src[6]), .insn_done_i,
    .vector_ack_i, .reti_i, .irq_req_o, .vector_addr_o, .ext_zero_pending_o, .ext_one_pending_o);
  task report_and_stop;
    begin
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // Bit writes carry the bit number in d[2:0] and the value in d[3].
  task w(input b, input [7:0] a, input [7:0] d);
    begin
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_bit_sel_i <= d[2:0];
      sfr_bit_val_i <= d[3];
      if (b) sfr_bit_wr_i <= 1'b1;
      else sfr_wr_i <= 1'b1;
      @(negedge clk_sys_i);
      sfr_wr_i <= 1'b0;
      sfr_bit_wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      sfr_addr_i <= a;
      @(negedge clk_sys_i);
      chk({8'h00, sfr_rdata_o}, {8'h00, e});
    end
  endtask
  task quiet(input integer n);
    repeat (n) begin
      @(negedge clk_sys_i);
      chk({15'h0000, irq_req_o}, 16'h0000);
    end
  endtask
  // Waits for a call, checks its vector, then lets the core ack it.
  task wait_irq(input [15:0] e);
    integer i;
    begin
      for (i = 0; i < 20 && irq_req_o !== 1'b1; i = i + 1) @(negedge clk_sys_i);
      if (i == 20) begin
        error_cnt = error_cnt + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, 16'h0000, e);
        report_and_stop;
      end else begin
        chk(vector_addr_o, e);
        @(negedge clk_sys_i);
      end
    end
  endtask
  task do_ret;
    begin
      ret <= 1'b1;
      @(negedge clk_sys_i);
      ret <= 1'b0;
      @(negedge clk_sys_i);
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    rd(`IRQ_MASK_REG_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    w(0, `IRQ_MASK_REG_ADDR, 8'h81);
    rd(`IRQ_MASK_REG_ADDR, 8'h81);
    w(1, `IRQ_MASK_REG_ADDR, 8'h07);
    rd(`IRQ_MASK_REG_ADDR, 8'h01);
    w(1, `IRQ_MASK_REG_ADDR, 8'h0f);
    rd(`IRQ_MASK_REG_ADDR, 8'h81);
    $display("test 1 done");
    w(0, `IRQ_MASK_REG_ADDR, 8'h7f);
    src <= 8'hfa;
    quiet(8);
    src <= 8'h00;
    $display("test 2 done");
    // Bit 7 stands for the high timer 2 flag, which shares mask bit 5.
    for (k = 0; k < 8; k = k + 1) begin
      m = (k == 7) ? 5 : k;
      w(0, `IRQ_MASK_REG_ADDR, 8'h80);
      src <= 8'h01 << k;
      quiet(8);
      if (k == 0) chk({15'h0000, ext_zero_pending_o}, 16'h0001);
      if (k == 2) chk({15'h0000, ext_one_pending_o}, 16'h0001);
      w(0, `IRQ_MASK_REG_ADDR, 8'h80 | (8'h01 << m));
      wait_irq(`VEC_BASE + `VEC_STEP * m);
      if (k == 0) chk({15'h0000, ext_zero_pending_o}, 16'h0000);
      if (k == 2) chk({15'h0000, ext_one_pending_o}, 16'h0000);
      src <= 8'h00;
      do_ret;
    end
    $display("test 3 done");
    w(0, `IRQ_MASK_REG_ADDR, 8'hff);
    src <= 8'h42;
    wait_irq(16'h000b);
    src <= 8'h40;
    do_ret;
    wait_irq(16'h0033);
    src <= 8'h00;
    do_ret;
    $display("test 4 done");
    w(0, `PRIO_REG_ADDR, 8'h08);
    rd(`PRIO_REG_ADDR, 8'h88);
    w(1, `PRIO_REG_ADDR, 8'h0e);
    rd(`PRIO_REG_ADDR, 8'hc8);
    src <= 8'h02;
    wait_irq(16'h000b);
    src <= 8'h40;
    wait_irq(16'h0033);
    src <= 8'h08;
    quiet(6);
    do_ret;
    wait_irq(16'h001b);
    src <= 8'h00;
    do_ret;
    do_ret;
    $display("test 5 done");
    nrst_i <= 1'b0;
    @(negedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    rd(`IRQ_MASK_REG_ADDR, 8'h00);
    $display("test 6 done");
    report_and_stop;
  end
endmodule
bind interrupt_enable_vectoring irq_checker i_chk (.clk_sys_i, .nrst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
  .sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_rdata_o, .insn_done_i, .vector_ack_i, .irq_req_o,
  .vector_addr_o, .ext_zero_pending_o, .ext_one_pending_o);
